/* radar_sweep_config_regs_defines.vh */
`ifndef RADAR_SWEEP_CONFIG_REGS_DEFINES_VH
`define RADAR_SWEEP_CONFIG_REGS_DEFINES_VH

// register offsets, configuration bank
`define OFS_WINDOW_BEGIN 8'h20
`define OFS_WINDOW_SPAN 8'h21
`define OFS_PACING 8'h22
`define OFS_RATE 8'h23
`define OFS_GAIN 8'h24
`define OFS_POWER 8'h25
`define OFS_TX_OFF 8'h26
`define OFS_PROFILE 8'h28
`define OFS_DECIMATION 8'h29
`define OFS_AVERAGE 8'h30
`define OFS_LEAKAGE 8'h32
`define OFS_ASYNC 8'h33
`define OFS_AMBIGUITY 8'h34
`define OFS_SWEEPS 8'h40
`define OFS_REQ_RATE 8'h41
`define OFS_SCHEME 8'h42
// register offsets, metadata bank
`define OFS_SWEEP_BEGIN 8'h81
`define OFS_SWEEP_SPAN 8'h82
`define OFS_WORD_COUNT 8'h83
`define OFS_ACT_RATE 8'h84
`define OFS_SPACING 8'h85
`define OFS_SATURATED 8'ha0
`define OFS_LOST 8'ha1
`define OFS_LINK_FAULT 8'ha4

// field codes
`define PACE_SENSOR 32'h0000_0001
`define PACE_FIRMWARE 32'h0000_0002
`define PWR_OFF 32'h0000_0000
`define PWR_SLEEP 32'h0000_0001
`define PWR_READY 32'h0000_0002
`define PWR_ACTIVE 32'h0000_0003
`define PWR_HIBERNATE 32'h0000_0004
`define PROFILE_MIN 32'h0000_0001
`define PROFILE_MAX 32'h0000_0005
`define GAIN_MAX 32'h0000_03e8
`define AMBIG_SHORT 32'h0000_0006
`define AMBIG_LONG 32'h0000_0009
`define SCHEME_MAX 32'h0000_0001

// reset values
`define RST_WINDOW_BEGIN 32'h0000_00c8
`define RST_WINDOW_SPAN 32'h0000_0320
`define RST_PACING 32'h0000_0002
`define RST_RATE 32'h0000_0000
`define RST_GAIN 32'h0000_01f4
`define RST_POWER 32'h0000_0003
`define RST_PROFILE 32'h0000_0001
`define RST_DECIMATION 32'h0000_0001
`define RST_AVERAGE 32'h0000_000a
`define RST_AMBIGUITY 32'h0000_0006
`define RST_SWEEPS 32'h0000_0010
`define RST_ZERO 32'h0000_0000

`endif

/* radar_sweep_config_regs.v */
// Summary of operation
// R01: writable registers hold host configuration driving the measurement service
// R02: metadata refreshes only on service create or new measurement data; the link fault flag also sets on LINK_FAULT_I
// R03: range begin and span are millimetre distances
// R04: pacing code 1 lets the sensor pace measurements at the set rate
// R05: pacing code 2 is a firmware rate limit; zero rate means unlimited
// R06: measurement rate is counted in millihertz
// R07: gain accepts zero (lowest) up to one thousand (highest)
// R08: power code 0 shuts the sensor down between sweeps
// R09: power codes 1 and 2 select sleep and ready
// R10: power code 3 keeps the whole sensor active
// R11: power code 4 is hibernate; host toggles a GPIO to enter and leave
// R12: profile accepts 1 to 5, depth resolution to loop gain
// R13: ambiguity code 6 gives 11.5 m, code 9 gives 17.3 m
// R14: requested sweep rate in millihertz; zero asks for the fastest
// R15: asynchronous register switches asynchronous measurement on or off
// R16: point spacing metadata reports micrometres between adjacent points
// R17: saturation flag set when captured data was saturated
// R18: lost-data flag reads true when measurement data was lost
// R19: link fault flag reads true after a sensor communication failure
// R20: writes to metadata leave it unchanged; reads have no side effects
`timescale 1ns/10ps
`include "radar_sweep_config_regs_defines.vh"

module radar_sweep_config_regs
(
   input wire CLK_I, // 25 MHz clock
   input wire RST_N_I, // synchronous reset, active low
   input wire [7:0] REG_ADDR_I, // register offset
   input wire REG_WR_I, // write strobe, one cycle
   input wire [31:0] REG_WDATA_I, // write data
   input wire REG_RD_I, // read strobe, one cycle
   output reg [31:0] REG_RDATA_O, // read data, valid with REG_RVALID_O
   output reg REG_RVALID_O, // read answer pulse
   output reg REG_WACK_O, // write accepted pulse
   output reg REG_ERR_O, // unmapped, read-only or out-of-range access pulse
   input wire SVC_CREATED_I, // service created pulse
   input wire DATA_PRODUCED_I, // new measurement data pulse
   input wire [31:0] SWEEP_BEGIN_MM_I, // sweep begin from service
   input wire [31:0] SWEEP_SPAN_MM_I, // sweep span from service
   input wire [31:0] RESULT_WORD_COUNT_I, // data length from service
   input wire [31:0] ACTUAL_SWEEP_RATE_I, // achieved sweep rate, mHz
   input wire [31:0] POINT_SPACING_UM_I, // point spacing, um
   input wire SATURATED_I, // data saturated, with DATA_PRODUCED_I
   input wire LOST_DATA_I, // data lost, with DATA_PRODUCED_I
   input wire LINK_FAULT_I, // sensor communication failure, level
   output reg [31:0] WINDOW_BEGIN_MM_O, // range begin, mm
   output reg [31:0] WINDOW_SPAN_MM_O, // range span, mm
   output reg [31:0] PACING_SELECT_O, // repetition mode
   output reg [31:0] RATE_MILLIHZ_O, // update rate, mHz
   output reg [31:0] RECEIVER_GAIN_O, // gain 0..1000
   output reg [31:0] POWER_STATE_O, // sensor power mode
   output reg [31:0] TRANSMITTER_OFF_O, // transmitter disable
   output reg [31:0] PROFILE_O, // rf profile
   output reg [31:0] DECIMATION_O, // downsampling factor
   output reg [31:0] AVERAGE_COUNT_O, // averaged samples per point
   output reg [31:0] LEAKAGE_MAX_O, // leakage attenuation setting
   output reg [31:0] ASYNC_ENABLE_O, // asynchronous mode
   output reg [31:0] AMBIGUITY_O, // unambiguous range code
   output reg [31:0] SWEEPS_PER_FRAME_O, // sweeps per frame
   output reg [31:0] REQ_SWEEP_RATE_O, // requested sweep rate, mHz
   output reg [31:0] SCHEME_O, // sampling mode
   output reg SENSOR_PACED_O, // sensor paces at set rate
   output reg FW_RATE_LIMIT_O, // firmware limits rate
   output reg FW_UNLIMITED_O, // firmware pacing with no limit
   output reg PWR_OFF_O, // shut down between sweeps
   output reg PWR_SLEEP_O, // sleep state
   output reg PWR_READY_O, // ready state
   output reg PWR_ACTIVE_O, // fully active
   output reg PWR_HIBERNATE_O, // oscillator stopped, host clocks via GPIO
   output reg LONG_RANGE_O, // 17.3 m unambiguous range selected
   output reg MAX_SWEEP_RATE_O, // fastest sweep rate requested
   output reg ASYNC_ON_O // asynchronous measurement running
);

   // metadata store
   reg [31:0] sweep_begin_mm;
   reg [31:0] sweep_span_mm;
   reg [31:0] result_word_count;
   reg [31:0] actual_sweep_rate;
   reg [31:0] point_spacing_um;
   reg saturation_flag;
   reg lost_data_flag;
   reg sensor_link_fault_flag;
   reg [31:0] next_rdata;
   reg rd_hit;
   reg wr_hit;
   reg wr_ok;
   wire refresh;

   // inclusive range check on a written value
   function in_range;
      input [31:0] v;
      input [31:0] lo;
      input [31:0] hi;
      begin
         in_range = (v >= lo) && (v <= hi);
      end
   endfunction

   // metadata other than the link fault flag takes new values only on these two events
   assign refresh = SVC_CREATED_I | DATA_PRODUCED_I; // [R02]

   // write decode: which offsets take writes and which values are legal
   always @*
   begin
      wr_hit = 1'b1;
      wr_ok = 1'b1;
      case (REG_ADDR_I)
         `OFS_WINDOW_BEGIN, `OFS_WINDOW_SPAN, `OFS_RATE, `OFS_TX_OFF,
         `OFS_DECIMATION, `OFS_AVERAGE, `OFS_LEAKAGE, `OFS_ASYNC,
         `OFS_SWEEPS, `OFS_REQ_RATE:
            wr_ok = 1'b1;
         `OFS_PACING:
            wr_ok = in_range(REG_WDATA_I, `PACE_SENSOR, `PACE_FIRMWARE); // [R04] [R05]
         `OFS_GAIN:
            wr_ok = in_range(REG_WDATA_I, `RST_ZERO, `GAIN_MAX); // [R07]
         `OFS_POWER:
            wr_ok = in_range(REG_WDATA_I, `PWR_OFF, `PWR_HIBERNATE); // [R08] [R09] [R10] [R11]
         `OFS_PROFILE:
            wr_ok = in_range(REG_WDATA_I, `PROFILE_MIN, `PROFILE_MAX); // [R12]
         `OFS_AMBIGUITY:
            wr_ok = (REG_WDATA_I == `AMBIG_SHORT) || (REG_WDATA_I == `AMBIG_LONG); // [R13]
         `OFS_SCHEME:
            wr_ok = in_range(REG_WDATA_I, `RST_ZERO, `SCHEME_MAX);
         default:
         begin
            wr_hit = 1'b0; // metadata and unmapped offsets refuse writes [R20]
            wr_ok = 1'b0;
         end
      endcase
   end

   // configuration registers, written by the host only
   always @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         WINDOW_BEGIN_MM_O <= `RST_WINDOW_BEGIN;
         WINDOW_SPAN_MM_O <= `RST_WINDOW_SPAN;
         PACING_SELECT_O <= `RST_PACING;
         RATE_MILLIHZ_O <= `RST_RATE;
         RECEIVER_GAIN_O <= `RST_GAIN;
         POWER_STATE_O <= `RST_POWER;
         TRANSMITTER_OFF_O <= `RST_ZERO;
         PROFILE_O <= `RST_PROFILE;
         DECIMATION_O <= `RST_DECIMATION;
         AVERAGE_COUNT_O <= `RST_AVERAGE;
         LEAKAGE_MAX_O <= `RST_ZERO;
         ASYNC_ENABLE_O <= `RST_ZERO;
         AMBIGUITY_O <= `RST_AMBIGUITY;
         SWEEPS_PER_FRAME_O <= `RST_SWEEPS;
         REQ_SWEEP_RATE_O <= `RST_ZERO;
         SCHEME_O <= `RST_ZERO;
      end
      else if (REG_WR_I && wr_ok)
      begin
         case (REG_ADDR_I) // [R01]
            `OFS_WINDOW_BEGIN: WINDOW_BEGIN_MM_O <= REG_WDATA_I; // [R03]
            `OFS_WINDOW_SPAN: WINDOW_SPAN_MM_O <= REG_WDATA_I; // [R03]
            `OFS_PACING: PACING_SELECT_O <= REG_WDATA_I;
            `OFS_RATE: RATE_MILLIHZ_O <= REG_WDATA_I; // [R06]
            `OFS_GAIN: RECEIVER_GAIN_O <= REG_WDATA_I;
            `OFS_POWER: POWER_STATE_O <= REG_WDATA_I;
            `OFS_TX_OFF: TRANSMITTER_OFF_O <= REG_WDATA_I;
            `OFS_PROFILE: PROFILE_O <= REG_WDATA_I;
            `OFS_DECIMATION: DECIMATION_O <= REG_WDATA_I;
            `OFS_AVERAGE: AVERAGE_COUNT_O <= REG_WDATA_I;
            `OFS_LEAKAGE: LEAKAGE_MAX_O <= REG_WDATA_I;
            `OFS_ASYNC: ASYNC_ENABLE_O <= REG_WDATA_I; // [R15]
            `OFS_AMBIGUITY: AMBIGUITY_O <= REG_WDATA_I;
            `OFS_SWEEPS: SWEEPS_PER_FRAME_O <= REG_WDATA_I;
            `OFS_REQ_RATE: REQ_SWEEP_RATE_O <= REG_WDATA_I; // [R14]
            `OFS_SCHEME: SCHEME_O <= REG_WDATA_I;
            default: SCHEME_O <= SCHEME_O;
         endcase
      end
   end

   // decoded controls, one cycle behind the registers they come from
   always @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         SENSOR_PACED_O <= 1'b0;
         FW_RATE_LIMIT_O <= 1'b0;
         FW_UNLIMITED_O <= 1'b0;
         PWR_OFF_O <= 1'b0;
         PWR_SLEEP_O <= 1'b0;
         PWR_READY_O <= 1'b0;
         PWR_ACTIVE_O <= 1'b0;
         PWR_HIBERNATE_O <= 1'b0;
         LONG_RANGE_O <= 1'b0;
         MAX_SWEEP_RATE_O <= 1'b0;
         ASYNC_ON_O <= 1'b0;
      end
      else
      begin
         SENSOR_PACED_O <= (PACING_SELECT_O == `PACE_SENSOR); // [R04]
         FW_RATE_LIMIT_O <= (PACING_SELECT_O == `PACE_FIRMWARE)
            && (RATE_MILLIHZ_O != `RST_ZERO); // [R05]
         FW_UNLIMITED_O <= (PACING_SELECT_O == `PACE_FIRMWARE)
            && (RATE_MILLIHZ_O == `RST_ZERO); // [R05]
         PWR_OFF_O <= (POWER_STATE_O == `PWR_OFF); // [R08]
         PWR_SLEEP_O <= (POWER_STATE_O == `PWR_SLEEP); // [R09]
         PWR_READY_O <= (POWER_STATE_O == `PWR_READY); // [R09]
         PWR_ACTIVE_O <= (POWER_STATE_O == `PWR_ACTIVE); // [R10]
         PWR_HIBERNATE_O <= (POWER_STATE_O == `PWR_HIBERNATE); // [R11]
         LONG_RANGE_O <= (AMBIGUITY_O == `AMBIG_LONG); // [R13]
         MAX_SWEEP_RATE_O <= (REQ_SWEEP_RATE_O == `RST_ZERO); // [R14]
         ASYNC_ON_O <= (ASYNC_ENABLE_O != `RST_ZERO); // [R15]
      end
   end

   // metadata capture; host writes never reach these
   always @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         sweep_begin_mm <= `RST_ZERO;
         sweep_span_mm <= `RST_ZERO;
         result_word_count <= `RST_ZERO;
         actual_sweep_rate <= `RST_ZERO;
         point_spacing_um <= `RST_ZERO;
         saturation_flag <= 1'b0;
         lost_data_flag <= 1'b0;
      end
      else if (refresh)
      begin
         sweep_begin_mm <= SWEEP_BEGIN_MM_I; // [R02]
         sweep_span_mm <= SWEEP_SPAN_MM_I;
         result_word_count <= RESULT_WORD_COUNT_I;
         actual_sweep_rate <= ACTUAL_SWEEP_RATE_I;
         point_spacing_um <= POINT_SPACING_UM_I; // [R16]
         saturation_flag <= DATA_PRODUCED_I & SATURATED_I; // [R17]
         lost_data_flag <= DATA_PRODUCED_I & LOST_DATA_I; // [R18]
      end
   end

   // link fault sticks until the service is created again; a new fault wins
   always @(posedge CLK_I)
   begin
      if (!RST_N_I)
         sensor_link_fault_flag <= 1'b0;
      else if (LINK_FAULT_I)
         sensor_link_fault_flag <= 1'b1; // [R19]
      else if (SVC_CREATED_I)
         sensor_link_fault_flag <= 1'b0;
   end

   // read multiplexer; selecting a register changes nothing
   always @*
   begin
      rd_hit = 1'b1;
      next_rdata = `RST_ZERO;
      case (REG_ADDR_I) // [R20]
         `OFS_WINDOW_BEGIN: next_rdata = WINDOW_BEGIN_MM_O;
         `OFS_WINDOW_SPAN: next_rdata = WINDOW_SPAN_MM_O;
         `OFS_PACING: next_rdata = PACING_SELECT_O;
         `OFS_RATE: next_rdata = RATE_MILLIHZ_O;
         `OFS_GAIN: next_rdata = RECEIVER_GAIN_O;
         `OFS_POWER: next_rdata = POWER_STATE_O;
         `OFS_TX_OFF: next_rdata = TRANSMITTER_OFF_O;
         `OFS_PROFILE: next_rdata = PROFILE_O;
         `OFS_DECIMATION: next_rdata = DECIMATION_O;
         `OFS_AVERAGE: next_rdata = AVERAGE_COUNT_O;
         `OFS_LEAKAGE: next_rdata = LEAKAGE_MAX_O;
         `OFS_ASYNC: next_rdata = ASYNC_ENABLE_O;
         `OFS_AMBIGUITY: next_rdata = AMBIGUITY_O;
         `OFS_SWEEPS: next_rdata = SWEEPS_PER_FRAME_O;
         `OFS_REQ_RATE: next_rdata = REQ_SWEEP_RATE_O;
         `OFS_SCHEME: next_rdata = SCHEME_O;
         `OFS_SWEEP_BEGIN: next_rdata = sweep_begin_mm;
         `OFS_SWEEP_SPAN: next_rdata = sweep_span_mm;
         `OFS_WORD_COUNT: next_rdata = result_word_count;
         `OFS_ACT_RATE: next_rdata = actual_sweep_rate;
         `OFS_SPACING: next_rdata = point_spacing_um; // [R16]
         `OFS_SATURATED: next_rdata = {31'h0000_0000, saturation_flag}; // [R17]
         `OFS_LOST: next_rdata = {31'h0000_0000, lost_data_flag}; // [R18]
         `OFS_LINK_FAULT: next_rdata = {31'h0000_0000, sensor_link_fault_flag}; // [R19]
         default: rd_hit = 1'b0;
      endcase
   end

   // answers to the register port, one cycle after the strobe
   always @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         REG_RDATA_O <= `RST_ZERO;
         REG_RVALID_O <= 1'b0;
         REG_WACK_O <= 1'b0;
         REG_ERR_O <= 1'b0;
      end
      else
      begin
         REG_RVALID_O <= REG_RD_I;
         if (REG_RD_I)
            REG_RDATA_O <= next_rdata;
         REG_WACK_O <= REG_WR_I & wr_hit & wr_ok;
         REG_ERR_O <= (REG_RD_I & ~rd_hit) | (REG_WR_I & ~(wr_hit & wr_ok)); // [R20]
      end
   end

endmodule // radar_sweep_config_regs

/* radar_sweep_config_regs_sva.sv */
`timescale 1ns/10ps
module radar_sweep_config_regs_chk
(
   input wire CLK_I, // register clock
   input wire RST_N_I, // reset, active low
   input wire [7:0] REG_ADDR_I, // offset
   input wire REG_WR_I, // write strobe
   input wire [31:0] REG_WDATA_I, // write data
   input wire REG_RD_I, // read strobe
   input wire [31:0] REG_RDATA_O, // read data
   input wire REG_RVALID_O, // read answer
   input wire REG_WACK_O, // write accepted
   input wire REG_ERR_O, // refused access
   input wire LINK_FAULT_I, // link fault report
   input wire [31:0] PACING_SELECT_O, // pacing code
   input wire [31:0] RECEIVER_GAIN_O, // gain
   input wire [31:0] POWER_STATE_O, // power code
   input wire [31:0] AMBIGUITY_O, // range code
   input wire SENSOR_PACED_O, // sensor paced
   input wire PWR_OFF_O, // off between sweeps
   input wire PWR_ACTIVE_O, // fully active
   input wire LONG_RANGE_O // long range
);
   // all checks run on the register clock and rest while reset is low
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // register port answers and refusals
   AST_GAIN_WRITE: assert property (
      REG_WR_I && REG_ADDR_I == 8'h24 && REG_WDATA_I <= 32'h3e8
      |=> REG_WACK_O && RECEIVER_GAIN_O == $past(REG_WDATA_I)) else $error("gain write lost");
   AST_GAIN_REFUSE: assert property (
      REG_WR_I && REG_ADDR_I == 8'h24 && REG_WDATA_I > 32'h3e8
      |=> REG_ERR_O && $stable(RECEIVER_GAIN_O)) else $error("gain out of range taken");
   AST_RO_WRITE: assert property (
      REG_WR_I && REG_ADDR_I inside {[8'h81:8'h85], 8'ha0, 8'ha1, 8'ha4}
      |=> REG_ERR_O && !REG_WACK_O) else $error("metadata write not refused");
   AST_GAIN_READ: assert property (
      REG_RD_I && REG_ADDR_I == 8'h24
      |=> REG_RVALID_O && REG_RDATA_O == $past(RECEIVER_GAIN_O)) else $error("gain read wrong");
   // decoded levels follow their register one cycle later; a link fault reads back as set
   AST_PACED: assert property (PACING_SELECT_O == 32'h1 |=> SENSOR_PACED_O)
      else $error("sensor pacing not decoded");
   AST_POWER: assert property (1'b1 |=> PWR_OFF_O == ($past(POWER_STATE_O) == 32'h0)
      && PWR_ACTIVE_O == ($past(POWER_STATE_O) == 32'h3)) else $error("power decode wrong");
   AST_LONG_RANGE: assert property (
      1'b1 |=> LONG_RANGE_O == ($past(AMBIGUITY_O) == 32'h9)) else $error("range decode wrong");
   AST_LINK_FAULT: assert property (
      LINK_FAULT_I ##1 (REG_RD_I && REG_ADDR_I == 8'ha4)
      |=> REG_RDATA_O == 32'h1) else $error("link fault not reported");
   // main scenarios reached
   COV_HIBERNATE: cover property (POWER_STATE_O == 32'h4);
   COV_REFUSED: cover property (REG_ERR_O);
   COV_LONG: cover property (LONG_RANGE_O);
endmodule // radar_sweep_config_regs_chk

bind radar_sweep_config_regs radar_sweep_config_regs_chk u_chk (.*);

/* radar_host_model.sv */
`timescale 1ns/10ps
module radar_host_model
(
   input wire clk_i, // register clock
   output logic [7:0] addr_o, // offset
   output logic wr_o, // write strobe
   output logic [31:0] wdata_o, // write data
   output logic rd_o, // read strobe
   input wire [31:0] rdata_i, // read data
   input wire rvalid_i, // read answer
   input wire wack_i, // write accepted
   input wire err_i // refused access
);
   // lines idle low until the first access
   initial
   begin
      {addr_o, wr_o, wdata_o, rd_o} = 42'h0;
   end
   // one strobe cycle; the answer stands only in the cycle after the taking edge,
   // so it is taken at the next falling edge, before the strobe is released
   task access(input logic w, r, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ack, val, bad);
      begin
         @(negedge clk_i);
         {addr_o, wr_o, wdata_o, rd_o} = {a, w, d, r};
         @(negedge clk_i);
         {q, ack, val, bad} = {rdata_i, wack_i, rvalid_i, err_i};
         {addr_o, wr_o, wdata_o, rd_o} = {~a, 1'b0, ~d, 1'b0}; // released lines lose the value
      end
   endtask
endmodule // radar_host_model

/* radar_sweep_config_regs_tb.sv */
`timescale 1ns/10ps
module radar_sweep_config_regs_tb;
   logic CLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   wire [7:0] REG_ADDR_I;
   wire REG_WR_I, REG_RD_I, REG_RVALID_O, REG_WACK_O, REG_ERR_O, SENSOR_PACED_O, FW_RATE_LIMIT_O;
   wire [31:0] REG_WDATA_I, REG_RDATA_O, WINDOW_BEGIN_MM_O, WINDOW_SPAN_MM_O, PACING_SELECT_O;
   wire [31:0] RATE_MILLIHZ_O, RECEIVER_GAIN_O, POWER_STATE_O, TRANSMITTER_OFF_O, PROFILE_O;
   wire [31:0] DECIMATION_O, AVERAGE_COUNT_O, LEAKAGE_MAX_O, ASYNC_ENABLE_O, AMBIGUITY_O;
   wire [31:0] SWEEPS_PER_FRAME_O, REQ_SWEEP_RATE_O, SCHEME_O;
   wire FW_UNLIMITED_O, PWR_OFF_O, PWR_SLEEP_O, PWR_READY_O, PWR_ACTIVE_O, PWR_HIBERNATE_O;
   wire LONG_RANGE_O, MAX_SWEEP_RATE_O, ASYNC_ON_O;
   logic SVC_CREATED_I = 1'b0, DATA_PRODUCED_I = 1'b0, SATURATED_I = 1'b0, LOST_DATA_I = 1'b0;
   logic LINK_FAULT_I = 1'b0;
   logic [31:0] SWEEP_BEGIN_MM_I = 32'h0, SWEEP_SPAN_MM_I = 32'h0, RESULT_WORD_COUNT_I = 32'h0;
   logic [31:0] ACTUAL_SWEEP_RATE_I = 32'h0, POINT_SPACING_UM_I = 32'h0;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] q;
   logic ack, val, bad;
   logic [31:0] model [256];
   localparam logic [7:0] CA [24] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28,
      8'h29, 8'h30, 8'h32, 8'h33, 8'h34, 8'h40, 8'h41, 8'h42,
      8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'ha0, 8'ha1, 8'ha4};
   localparam logic [31:0] RV [16] = '{32'hc8, 32'h320, 32'h2, 32'h0, 32'h1f4, 32'h3, 32'h0,
      32'h1, 32'h1, 32'ha, 32'h0, 32'h0, 32'h6, 32'h10, 32'h0, 32'h0};
   // offset, write value, refusal expected
   localparam logic [47:0] ROWS [36] = '{48'h20_0000012c_00, 48'h21_000003e8_00,
      48'h22_00000001_00, 48'h22_00000003_01, 48'h22_00000002_00, 48'h22_00000000_01,
      48'h23_000001f4_00, 48'h24_00000000_00, 48'h24_000003e8_00, 48'h24_000003e9_01,
      48'h25_00000000_00, 48'h25_00000001_00, 48'h25_00000002_00, 48'h25_00000004_00,
      48'h25_00000005_01, 48'h25_00000003_00, 48'h26_00000001_00, 48'h28_00000005_00,
      48'h28_00000006_01, 48'h28_00000000_01, 48'h28_00000001_00, 48'h29_00000002_00,
      48'h30_00000004_00, 48'h32_00000001_00, 48'h33_00000001_00, 48'h34_00000009_00,
      48'h34_00000007_01, 48'h40_00000008_00, 48'h41_000007d0_00, 48'h41_00000000_00,
      48'h42_00000001_00, 48'h42_00000002_01, 48'h81_00000055_01, 48'h85_00000055_01,
      48'ha0_00000001_01, 48'ha4_00000001_01};

   radar_host_model u_radar_host_model (.clk_i(CLK_I), .addr_o(REG_ADDR_I), .wr_o(REG_WR_I),
      .wdata_o(REG_WDATA_I), .rd_o(REG_RD_I), .rdata_i(REG_RDATA_O), .rvalid_i(REG_RVALID_O),
      .wack_i(REG_WACK_O), .err_i(REG_ERR_O));
   radar_sweep_config_regs u_radar_sweep_config_regs (.*);

   // 25 MHz clock
   initial
   begin
      forever #20 CLK_I = ~CLK_I;
   end
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      begin
         check_count++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   // configuration port that belongs to an offset; zero for any other offset
   function automatic logic [31:0] cfg_out(input logic [7:0] a);
      case (a)
         8'h20: cfg_out = WINDOW_BEGIN_MM_O;
         8'h21: cfg_out = WINDOW_SPAN_MM_O;
         8'h22: cfg_out = PACING_SELECT_O;
         8'h23: cfg_out = RATE_MILLIHZ_O;
         8'h24: cfg_out = RECEIVER_GAIN_O;
         8'h25: cfg_out = POWER_STATE_O;
         8'h26: cfg_out = TRANSMITTER_OFF_O;
         8'h28: cfg_out = PROFILE_O;
         8'h29: cfg_out = DECIMATION_O;
         8'h30: cfg_out = AVERAGE_COUNT_O;
         8'h32: cfg_out = LEAKAGE_MAX_O;
         8'h33: cfg_out = ASYNC_ENABLE_O;
         8'h34: cfg_out = AMBIGUITY_O;
         8'h40: cfg_out = SWEEPS_PER_FRAME_O;
         8'h41: cfg_out = REQ_SWEEP_RATE_O;
         8'h42: cfg_out = SCHEME_O;
         default: cfg_out = 32'h0;
      endcase
   endfunction
   // decoded control levels against the codes held in the model
   task chk_decoded;
      chk32({21'h0, SENSOR_PACED_O, FW_RATE_LIMIT_O, FW_UNLIMITED_O, PWR_OFF_O, PWR_SLEEP_O,
         PWR_READY_O, PWR_ACTIVE_O, PWR_HIBERNATE_O, LONG_RANGE_O, MAX_SWEEP_RATE_O, ASYNC_ON_O},
         {21'h0, model[8'h22] == 32'h1, model[8'h22] == 32'h2 && model[8'h23] != 32'h0,
         model[8'h22] == 32'h2 && model[8'h23] == 32'h0, model[8'h25] == 32'h0,
         model[8'h25] == 32'h1, model[8'h25] == 32'h2, model[8'h25] == 32'h3,
         model[8'h25] == 32'h4, model[8'h34] == 32'h9, model[8'h41] == 32'h0,
         model[8'h33] != 32'h0});
   endtask
   task acc(input logic w, r, input logic [7:0] a, input logic [31:0] d);
      u_radar_host_model.access(w, r, a, d, q, ack, val, bad);
   endtask
   // every register reads its reset value; metadata and flags read zero
   task check_resets;
      begin
         for (int i = 0; i < 24; i++)
         begin
            model[CA[i]] = (i < 16) ? RV[i] : 32'h0;
            acc(1'b0, 1'b1, CA[i], 32'h0);
            chk32(q, model[CA[i]]);
            chk32(cfg_out(CA[i]), model[CA[i]]);
         end
         chk_decoded;
      end
   endtask
   // a refresh pulse captures metadata; later input changes are ignored
   task event_pulse(input logic svc, input logic [31:0] base);
      begin
         @(negedge CLK_I);
         {SWEEP_BEGIN_MM_I, SWEEP_SPAN_MM_I, RESULT_WORD_COUNT_I} = {base, base + 32'h1, base + 32'h2};
         {ACTUAL_SWEEP_RATE_I, POINT_SPACING_UM_I} = {base + 32'h3, base + 32'h4};
         {SVC_CREATED_I, DATA_PRODUCED_I, SATURATED_I, LOST_DATA_I} = {svc, !svc, 2'b11};
         @(negedge CLK_I);
         {SVC_CREATED_I, DATA_PRODUCED_I, SATURATED_I, LOST_DATA_I} = 4'h0;
         SWEEP_BEGIN_MM_I = ~base;
         POINT_SPACING_UM_I = ~base;
         for (int i = 16; i < 24; i++)
         begin
            acc(1'b0, 1'b1, CA[i], 32'h0);
            chk32(q, (i < 21) ? base + (i - 16) : {31'h0, (i < 23) && !svc});
         end
      end
   endtask
   task stop_test;
      begin
         $display("compares %0d mismatches %0d", check_count, n_mismatch);
         if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // watchdog against a hang
   initial
   begin
      #1000000;
      n_mismatch++;
      stop_test;
   end
   // main sequence
   initial
   begin
      repeat (6) @(negedge CLK_I);
      RST_N_I = 1'b1;
      check_resets;
      foreach (ROWS[i])
      begin
         acc(1'b1, 1'b0, ROWS[i][47:40], ROWS[i][39:8]);
         chk1(ack, !ROWS[i][0]);
         chk1(bad, ROWS[i][0]);
         if (!ROWS[i][0])
            model[ROWS[i][47:40]] = ROWS[i][39:8];
         acc(1'b0, 1'b1, ROWS[i][47:40], 32'h0);
         chk32(q, model[ROWS[i][47:40]]);
         chk32(cfg_out(ROWS[i][47:40]), model[ROWS[i][47:40]]);
         chk_decoded;
      end
      chk1(LONG_RANGE_O, 1'b1);
      chk1(ASYNC_ON_O, 1'b1);
      chk1(FW_RATE_LIMIT_O, 1'b1);
      chk1(PWR_ACTIVE_O, 1'b1);
      // read and write in one cycle: the read returns the old value
      acc(1'b1, 1'b1, 8'h24, 32'h64);
      chk1(ack & val, 1'b1);
      chk32(q, model[8'h24]);
      acc(1'b0, 1'b1, 8'h24, 32'h0);
      chk32(q, 32'h64);
      // unmapped offset is refused both ways
      acc(1'b1, 1'b0, 8'h27, 32'h1);
      chk1(bad, 1'b1);
      acc(1'b0, 1'b1, 8'h27, 32'h0);
      chk32({q[31:2], val, bad}, 32'h3);
      event_pulse(1'b0, 32'h100);
      // link fault is sticky until the service is created again
      LINK_FAULT_I = 1'b1;
      acc(1'b0, 1'b1, 8'ha4, 32'h0);
      LINK_FAULT_I = 1'b0;
      chk32(q, 32'h1);
      acc(1'b0, 1'b1, 8'ha4, 32'h0);
      chk32(q, 32'h1);
      event_pulse(1'b1, 32'h200);
      // second reset in mid-run
      RST_N_I = 1'b0;
      repeat (2) @(negedge CLK_I);
      RST_N_I = 1'b1;
      check_resets;
      stop_test;
   end
endmodule // radar_sweep_config_regs_tb
